// >>> rtl/icm_map.svh
// register addresses, field positions and reset values of the interrupt
// control and mask block; included by the design files by bare name.
`ifndef ICM_MAP_SVH
`define ICM_MAP_SVH

// per-source control registers, one byte each, in source order
`define ICM_CTRL_BASE 16'hffe0
`define ICM_CTRL_RESET 8'h43
// mask bytes: low bank lower, low bank upper, high bank lower, upper
`define ICM_MASK_BASE 16'hffac
`define ICM_MASK_RESET 16'hffff
`define ICM_NUM_SRC 27

// field positions inside a per-source control byte
`define ICM_IF_BIT 7
`define ICM_MK_BIT 6
`define ICM_ISM_BIT 5
`define ICM_CSE_BIT 4
`define ICM_PR_MSB 1
`define ICM_PR_LSB 0

`endif

// >>> rtl/icm_pkg.sv
// types shared by the interrupt control and mask block.
// assumes the address map header is compiled alongside.
package icm_pkg;

  typedef logic [1:0] icm_level_t;

  // servicing style reported with a presented request
  typedef enum logic [2:0] {
    ICM_VECTORED = 3'h1,
    ICM_CONTEXT = 3'h2,
    ICM_MACRO = 3'h4
  } icm_mode_t;

endpackage : icm_pkg

// >>> rtl/icm_arbiter.sv
// priority selection among pending, unmasked interrupt sources.
// purely combinational; the caller registers the result.
`timescale 1ns/1ps
module icm_arbiter
  import icm_pkg::*;
#(
  parameter int NUM_SRC = 27,
  parameter int SW = 5
) (
  input wire logic [NUM_SRC-1:0] pend_i, // flag set and mask clear
  input wire logic [2*NUM_SRC-1:0] prio_i, // two bits per source
  output logic found_o, // some source is eligible
  output logic [SW-1:0] src_o, // chosen source index
  output icm_level_t level_o // its priority level
);

  always_comb begin
    found_o = 1'b0;
    src_o = '0;
    level_o = '1;
    // strict compare keeps the lower index on a tie: fixed default order
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_i[i] && (!found_o || prio_i[2*i +: 2] < level_o)) begin
        found_o = 1'b1;
        src_o = SW'(i);
        level_o = prio_i[2*i +: 2];
      end
    end
  end

endmodule : icm_arbiter

// >>> rtl/icm_ctrl_mask.sv
// per-source interrupt control registers, en-bloc mask registers and the
// request selection that presents the winning source to the cpu core.
// assumes cpu accesses are single-cycle strobes synchronous to ref_clk_i
// and that peripheral request pulses are synchronous too.
`timescale 1ns/1ps
`include "icm_map.svh"
module icm_ctrl_mask
  import icm_pkg::*;
#(
  parameter int NUM_SRC = `ICM_NUM_SRC,
  parameter int SW = $clog2(NUM_SRC)
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [15:0] cpu_addr_i, // byte address of the access
  input wire logic cpu_wr_i, // write strobe
  input wire logic cpu_rd_i, // read strobe
  input wire logic cpu_word_i, // 16-bit access (mask banks only)
  input wire logic cpu_bit_i, // single-bit operation
  input wire logic [2:0] cpu_bit_sel_i, // bit within the byte
  input wire logic [15:0] cpu_wdata_i, // write data; bit op uses bit 0
  input wire logic cpu_ack_i, // core takes the presented request
  input wire logic [NUM_SRC-1:0] src_req_i, // peripheral request pulses
  input wire logic ms_done_i, // macro service counter reached zero
  input wire logic [SW-1:0] ms_src_i, // source whose service ended
  output logic [15:0] cpu_rdata_o, // read data, one cycle after strobe
  output logic cpu_hit_o, // last read hit a mapped register
  output logic cpu_bit_o, // tested bit of the last read
  output logic int_req_o, // a request is presented
  output logic [SW-1:0] int_src_o, // presented source index
  output icm_level_t int_level_o, // its priority level
  output icm_mode_t int_mode_o // its servicing style
);

  localparam logic [7:0] RST_CTRL = `ICM_CTRL_RESET;
  localparam logic [15:0] CTRL_BASE = `ICM_CTRL_BASE;
  localparam logic [15:0] MASK_BASE = `ICM_MASK_BASE;

  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] mask_q;
  logic [NUM_SRC-1:0] macro_q;
  logic [NUM_SRC-1:0] ctx_q;
  logic [NUM_SRC-1:0][1:0] prio_q;
  logic [NUM_SRC-1:0] next_flag;
  logic [NUM_SRC-1:0] next_mask;
  logic [NUM_SRC-1:0] next_macro;
  logic [NUM_SRC-1:0] next_ctx;
  logic [NUM_SRC-1:0][1:0] next_prio;

  logic ctrl_hit;
  logic mask_hit;
  logic [SW-1:0] ctrl_idx;
  logic [1:0] mask_byte;
  logic ack_take;
  logic [15:0] rd_val;
  logic rd_hit;
  logic arb_found;
  logic [SW-1:0] arb_src;
  icm_level_t arb_level;

  // write data for a byte register: whole byte, or one bit set or cleared
  function automatic logic [7:0] byte_update(input logic [7:0] old_b,
                                             input logic [7:0] d,
                                             input logic is_bit,
                                             input logic [2:0] sel,
                                             input logic val);
    logic [7:0] r;
    r = old_b;
    if (is_bit) begin
      r[sel] = val;
    end else begin
      r = d;
    end
    return r;
  endfunction : byte_update

  function automatic logic [7:0] ctrl_byte(input logic f, input logic m,
                                           input logic s, input logic c,
                                           input logic [1:0] p);
    logic [7:0] b;
    b = '0;
    b[`ICM_IF_BIT] = f;
    b[`ICM_MK_BIT] = m;
    b[`ICM_ISM_BIT] = s;
    b[`ICM_CSE_BIT] = c;
    b[`ICM_PR_MSB:`ICM_PR_LSB] = p;
    return b;
  endfunction : ctrl_byte

  // word access is only meaningful on the mask banks, at even addresses
  assign ctrl_hit = !cpu_word_i && (cpu_addr_i >= CTRL_BASE) &&
                    (cpu_addr_i < CTRL_BASE + 16'(NUM_SRC));
  assign mask_hit = (cpu_addr_i[15:2] == MASK_BASE[15:2]) &&
                    !(cpu_word_i && cpu_addr_i[0]) &&
                    !(cpu_word_i && cpu_bit_i);
  assign ctrl_idx = SW'(cpu_addr_i - CTRL_BASE);
  assign mask_byte = cpu_addr_i[1:0];
  assign ack_take = cpu_ack_i && int_req_o && !mask_q[int_src_o];

  always_comb begin
    logic [7:0] b;
    logic [31:0] m32;
    b = '0;
    m32 = '1;
    next_flag = flag_q;
    next_mask = mask_q;
    next_macro = macro_q;
    next_ctx = ctx_q;
    next_prio = prio_q;
    // hardware clears first so that a software write the same cycle wins
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ack_take && int_src_o == SW'(i)) begin
        next_flag[i] = 1'b0;
      end
      if (ms_done_i && ms_src_i == SW'(i)) begin
        next_macro[i] = 1'b0;
      end
      if (cpu_wr_i && ctrl_hit && ctrl_idx == SW'(i)) begin
        b = byte_update(ctrl_byte(flag_q[i], mask_q[i], macro_q[i],
                                  ctx_q[i], prio_q[i]),
                        cpu_wdata_i[7:0], cpu_bit_i, cpu_bit_sel_i,
                        cpu_wdata_i[0]);
        next_flag[i] = b[`ICM_IF_BIT];
        next_mask[i] = b[`ICM_MK_BIT];
        next_macro[i] = b[`ICM_ISM_BIT];
        next_ctx[i] = b[`ICM_CSE_BIT];
        next_prio[i] = b[`ICM_PR_MSB:`ICM_PR_LSB];
      end
    end
    // the banks are a second view of the same mask flops
    m32[NUM_SRC-1:0] = mask_q;
    if (cpu_wr_i && mask_hit) begin
      if (cpu_word_i) begin
        m32[{mask_byte, 3'h0} +: 16] = cpu_wdata_i;
      end else begin
        m32[{mask_byte, 3'h0} +: 8] = byte_update(
            m32[{mask_byte, 3'h0} +: 8], cpu_wdata_i[7:0], cpu_bit_i,
            cpu_bit_sel_i, cpu_wdata_i[0]);
      end
      next_mask = m32[NUM_SRC-1:0];
    end
    // a new request beats any clear in the same cycle
    next_flag = next_flag | src_req_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_q <= {NUM_SRC{RST_CTRL[`ICM_IF_BIT]}};
      mask_q <= NUM_SRC'(`ICM_MASK_RESET | 32'hffffffff);
      macro_q <= {NUM_SRC{RST_CTRL[`ICM_ISM_BIT]}};
      ctx_q <= {NUM_SRC{RST_CTRL[`ICM_CSE_BIT]}};
      prio_q <= {NUM_SRC{RST_CTRL[`ICM_PR_MSB:`ICM_PR_LSB]}};
    end else begin
      flag_q <= next_flag;
      mask_q <= next_mask;
      macro_q <= next_macro;
      ctx_q <= next_ctx;
      prio_q <= next_prio;
    end
  end

  // read side: value before any write of the same cycle
  always_comb begin
    logic [31:0] m32;
    m32 = '1;
    m32[NUM_SRC-1:0] = mask_q;
    rd_val = '0;
    rd_hit = 1'b0;
    if (ctrl_hit) begin
      rd_hit = 1'b1;
      rd_val[7:0] = ctrl_byte(flag_q[ctrl_idx], mask_q[ctrl_idx],
                              macro_q[ctrl_idx], ctx_q[ctrl_idx],
                              prio_q[ctrl_idx]);
    end else if (mask_hit) begin
      rd_hit = 1'b1;
      if (cpu_word_i) begin
        rd_val = m32[{mask_byte, 3'h0} +: 16];
      end else begin
        rd_val[7:0] = m32[{mask_byte, 3'h0} +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cpu_rdata_o <= '0;
      cpu_hit_o <= 1'b0;
      cpu_bit_o <= 1'b0;
    end else if (cpu_rd_i) begin
      cpu_rdata_o <= rd_val;
      cpu_hit_o <= rd_hit;
      cpu_bit_o <= rd_val[cpu_bit_sel_i];
    end
  end

  icm_arbiter #(
    .NUM_SRC(NUM_SRC),
    .SW(SW)
  ) u_arb (
    .pend_i(flag_q & ~mask_q),
    .prio_i(prio_q),
    .found_o(arb_found),
    .src_o(arb_src),
    .level_o(arb_level)
  );

  // after an acknowledgment the presented source is withdrawn for one
  // cycle, since the cleared flag only reaches the selection a cycle later
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      int_req_o <= 1'b0;
      int_src_o <= '0;
      int_level_o <= '1;
      int_mode_o <= ICM_VECTORED;
    end else begin
      int_req_o <= arb_found && !ack_take;
      int_src_o <= arb_src;
      int_level_o <= arb_level;
      if (macro_q[arb_src]) begin
        int_mode_o <= ICM_MACRO;
      end else if (ctx_q[arb_src]) begin
        int_mode_o <= ICM_CONTEXT;
      end else begin
        int_mode_o <= ICM_VECTORED;
      end
    end
  end

  // helper state seen only by the checks below
  logic [NUM_SRC-1:0] mask_prev;
  logic [NUM_SRC-1:0] pend_prev;
  logic [NUM_SRC-1:0] macro_prev;
  logic [NUM_SRC-1:0] ctx_prev;
  logic [NUM_SRC-1:0][1:0] prio_prev;
  logic better_seen;
  logic tie_seen;

  always_ff @(posedge ref_clk_i) begin
    mask_prev <= mask_q;
    pend_prev <= flag_q & ~mask_q;
    macro_prev <= macro_q;
    ctx_prev <= ctx_q;
    prio_prev <= prio_q;
  end

  always_comb begin
    better_seen = 1'b0;
    tie_seen = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_prev[i] && prio_prev[i] < int_level_o) begin
        better_seen = 1'b1;
      end
      if (pend_prev[i] && prio_prev[i] == int_level_o &&
          SW'(i) < int_src_o) begin
        tie_seen = 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence word_wr_s;
    cpu_wr_i && cpu_word_i && !cpu_bit_i && cpu_addr_i == MASK_BASE;
  endsequence

  sequence hi_byte_wr_s;
    cpu_wr_i && !cpu_word_i && !cpu_bit_i &&
    cpu_addr_i == MASK_BASE + 16'h1;
  endsequence

  sequence mask_bit_op_s;
    cpu_wr_i && cpu_bit_i && !cpu_word_i && cpu_addr_i == MASK_BASE;
  endsequence

  ctrl_read_fmt_a: assert property (
    cpu_rd_i && ctrl_hit |=> cpu_hit_o && cpu_rdata_o[15:8] == 8'h00 &&
    cpu_rdata_o[3:2] == 2'b00)
    else $error("control byte read shows nonzero reserved bits");

  req_sets_flag_a: assert property (
    src_req_i != '0 |=> (flag_q & $past(src_req_i)) == $past(src_req_i))
    else $error("request pulse did not set its flag");

  masked_never_shown_a: assert property (
    int_req_o |-> !mask_prev[int_src_o])
    else $error("masked source presented to the core");

  unmasked_shown_a: assert property (
    (flag_q & ~mask_q) != '0 && !ack_take |=> int_req_o)
    else $error("eligible request not presented");

  macro_style_a: assert property (
    int_req_o |-> (int_mode_o == ICM_MACRO) == macro_prev[int_src_o])
    else $error("macro service style mismatch");

  context_style_a: assert property (
    int_req_o && !macro_prev[int_src_o] |->
    (int_mode_o == ICM_CONTEXT) == ctx_prev[int_src_o])
    else $error("context switch style mismatch");

  level_reported_a: assert property (
    int_req_o |-> int_level_o == prio_prev[int_src_o] && !better_seen)
    else $error("presented level is not the best pending level");

  word_write_a: assert property (
    word_wr_s |=> mask_q[15:0] == $past(cpu_wdata_i))
    else $error("word write to low mask bank lost");

  byte_write_a: assert property (
    hi_byte_wr_s |=> mask_q[15:8] == $past(cpu_wdata_i[7:0]) &&
    $stable(mask_q[7:0]))
    else $error("upper byte write disturbed or missed");

  bit_op_a: assert property (
    mask_bit_op_s |=> mask_q[$past(cpu_bit_sel_i)] == $past(cpu_wdata_i[0])
    && $countones(mask_q ^ $past(mask_q)) <= 1)
    else $error("single-bit mask operation touched other bits");

  alias_view_a: assert property (
    cpu_wr_i && ctrl_hit && !cpu_bit_i |=>
    mask_q[$past(ctrl_idx)] == $past(cpu_wdata_i[`ICM_MK_BIT]))
    else $error("control mask write not seen in mask bank");

  mask_reset_a: assert property (
    $fell(rst_i) |-> &mask_q)
    else $error("mask banks not all ones after reset");

  ack_clears_a: assert property (
    ack_take && !src_req_i[int_src_o] && !cpu_wr_i |=>
    !flag_q[$past(int_src_o)] ##1
    (!int_req_o || int_src_o != $past(int_src_o, 2)))
    else $error("acknowledged flag not cleared");

  macro_end_a: assert property (
    ms_done_i && !cpu_wr_i |=> !macro_q[$past(ms_src_i)])
    else $error("macro select survived end of service");

  tie_order_a: assert property (
    int_req_o |-> !tie_seen)
    else $error("tie not resolved in fixed source order");

  winner_shown_a: assert property (
    int_req_o |-> pend_prev[int_src_o])
    else $error("presented source was not pending");

endmodule : icm_ctrl_mask

// >>> test/icm_src_model.sv
// partner model: peripheral request sources and the core's acknowledge.
// assumes the block clock; drives only on falling edges.
`timescale 1ns/1ps
module icm_src_model #(
  parameter int NUM_SRC = 27
) (
  input wire logic clk_i, // block clock
  input wire logic int_req_i, // presented request
  output logic [NUM_SRC-1:0] src_req_o, // request pulses
  output logic ack_o // acknowledge pulse
);
  initial begin
    src_req_o = '0;
    ack_o = 1'b0;
  end

  // one-cycle pulse on every source named in vec
  task raise(input logic [NUM_SRC-1:0] vec);
    @(negedge clk_i);
    src_req_o = vec;
    @(negedge clk_i);
    src_req_o = '0;
  endtask : raise

  // the core only takes a request that is presented
  task take();
    @(negedge clk_i);
    ack_o = int_req_i;
    @(negedge clk_i);
    ack_o = 1'b0;
  endtask : take
endmodule : icm_src_model

// >>> test/icm_ctrl_mask_tb_top.sv
// testbench of the interrupt control and mask block.
// assumes the design files and the address map header are compiled first.
`timescale 1ns/1ps
`include "icm_map.svh"
module icm_ctrl_mask_tb_top import icm_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic word = 1'b0;
  logic bop = 1'b0;
  logic [2:0] sel = 3'h0;
  logic ms_done = 1'b0;
  logic [4:0] ms_src = 5'h00;
  logic [15:0] rdata;
  logic hit;
  logic tbit;
  logic int_req;
  logic [4:0] isrc;
  icm_level_t ilvl;
  icm_mode_t imode;
  logic [26:0] sreq;
  logic ack;
  int errors = 0;
  int num_checks = 0;
  int esrc[3] = '{9, 12, 7};
  logic [15:0] elvl[3] = '{16'h0001, 16'h0001, 16'h0002};
  logic [7:0] mval[4] = '{8'h00, 8'h10, 8'h20, 8'h30};
  logic [15:0] emode[4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004};

  always #12.5 ref_clk = ~ref_clk;

  icm_ctrl_mask DUT (.ref_clk_i(ref_clk), .rst_i(rst), .cpu_addr_i(addr),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_word_i(word), .cpu_bit_i(bop),
    .cpu_bit_sel_i(sel), .cpu_wdata_i(wdata), .cpu_ack_i(ack),
    .src_req_i(sreq), .ms_done_i(ms_done), .ms_src_i(ms_src),
    .cpu_rdata_o(rdata), .cpu_hit_o(hit), .cpu_bit_o(tbit),
    .int_req_o(int_req), .int_src_o(isrc), .int_level_o(ilvl),
    .int_mode_o(imode));

  icm_src_model #(.NUM_SRC(27)) model (.clk_i(ref_clk), .int_req_i(int_req),
    .src_req_o(sreq), .ack_o(ack));

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk

  // one strobe cycle; strobes drop at the next falling edge
  task acc(input logic [15:0] a, input logic [15:0] d, input logic w,
           input logic wd, input logic b, input logic [2:0] s);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    word = wd;
    bop = b;
    sel = s;
    @(negedge ref_clk);
    wr = 1'b0;
    rd = 1'b0;
    word = 1'b0;
    bop = 1'b0;
  endtask : acc

  function automatic logic [15:0] ctl(input int i);
    ctl = `ICM_CTRL_BASE + 16'(i);
  endfunction : ctl

  task rdc(input logic [15:0] a, input logic wd, input logic [15:0] e);
    acc(a, 16'h0000, 1'b0, wd, 1'b0, 3'h0);
    chk("read data", e, rdata);
  endtask : rdc

  // presentation comes within a few cycles; bounded wait
  task wait_req();
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk("int_req", 16'h0001, {15'h0000, int_req});
  endtask : wait_req

  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    #(25ns * 20000);
    errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 27; i++) rdc(ctl(i), 1'b0, 16'h0043);
    rdc(16'hffac, 1'b1, 16'hffff);
    rdc(16'hffae, 1'b1, 16'hffff);
    acc(ctl(0), 16'h00ff, 1'b1, 1'b0, 1'b0, 3'h0);
    rdc(ctl(0), 1'b0, 16'h00f3);
    $display("test reset values done");
    model.raise(27'h0000020);
    repeat (8) @(negedge ref_clk);
    chk("masked int_req", 16'h0000, {15'h0000, int_req});
    rdc(ctl(5), 1'b0, 16'h00c3);
    acc(16'hffac, 16'h0000, 1'b1, 1'b0, 1'b1, 3'h5);
    wait_req();
    chk("src", 16'h0005, {11'h000, isrc});
    chk("level", 16'h0003, {14'h0000, ilvl});
    chk("mode", 16'h0001, {13'h0000, imode});
    model.take();
    rdc(ctl(5), 1'b0, 16'h0003);
    $display("test mask and acknowledge done");
    acc(ctl(7), 16'h0002, 1'b1, 1'b0, 1'b0, 3'h0);
    acc(ctl(9), 16'h0001, 1'b1, 1'b0, 1'b0, 3'h0);
    acc(ctl(12), 16'h0001, 1'b1, 1'b0, 1'b0, 3'h0);
    model.raise(27'h0001280);
    for (int k = 0; k < 3; k++) begin
      wait_req();
      chk("win src", 16'(esrc[k]), {11'h000, isrc});
      chk("win level", elvl[k], {14'h0000, ilvl});
      model.take();
    end
    $display("test priority done");
    for (int k = 0; k < 4; k++) begin
      acc(ctl(3), {8'h00, mval[k]}, 1'b1, 1'b0, 1'b0, 3'h0);
      model.raise(27'h0000008);
      wait_req();
      chk("style", emode[k], {13'h0000, imode});
      chk("level0", 16'h0000, {14'h0000, ilvl});
      model.take();
    end
    @(negedge ref_clk);
    ms_done = 1'b1;
    ms_src = 5'h03;
    @(negedge ref_clk);
    ms_done = 1'b0;
    rdc(ctl(3), 1'b0, 16'h0010);
    $display("test servicing style done");
    acc(16'hffac, 16'h1234, 1'b1, 1'b1, 1'b0, 3'h0);
    rdc(16'hffac, 1'b0, 16'h0034);
    rdc(16'hffad, 1'b0, 16'h0012);
    rdc(ctl(1), 1'b0, 16'h0003);
    acc(ctl(10), 16'h0041, 1'b1, 1'b0, 1'b0, 3'h0);
    rdc(16'hffac, 1'b1, 16'h1634);
    acc(16'hffad, 16'h0001, 1'b1, 1'b0, 1'b1, 3'h3);
    acc(16'hffad, 16'h0000, 1'b0, 1'b0, 1'b1, 3'h3);
    chk("bit test", 16'h0001, {15'h0000, tbit});
    acc(16'hffac, 16'h0000, 1'b1, 1'b0, 1'b1, 3'h2);
    rdc(16'hffac, 1'b1, 16'h1e30);
    acc(16'hffae, 16'h0000, 1'b1, 1'b1, 1'b0, 3'h0);
    rdc(16'hffae, 1'b1, 16'hf800);
    rdc(16'h0000, 1'b0, 16'h0000);
    chk("unmapped hit", 16'h0000, {15'h0000, hit});
    $display("test mask views done");
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    rdc(16'hffae, 1'b1, 16'hffff);
    chk("mapped hit", 16'h0001, {15'h0000, hit});
    $display("test second reset done");
    complete_run();
  end
endmodule : icm_ctrl_mask_tb_top
